// [bench/analog_front_model.sv]
// Analog input and comparator beside the converter control block
// Assumes one analog line selected; level in code steps, may exceed rails
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
  input wire logic [7:0] trial_in,
  input wire logic signed [9:0] level_in,
  output logic cmp_high_out
);
  assign cmp_high_out = level_in >= $signed({2'b00, trial_in});
endmodule
`default_nettype wire

// [bench/test_adc_conversion_control.sv]
// Self-checking bench for the converter control block
// Assumes analog_front_model drives the comparator; 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_control;
  localparam int CONV_CLK = adc_ctrl_pkg::CONV_TICKS * adc_ctrl_pkg::CLK_DIV;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pd = 1'b1;
  logic ie = 1'b0;
  logic start = 1'b0;
  logic ce = 1'b1;
  logic signed [9:0] level = 10'sd0;
  logic cmp_high, power, busy, eoc, irq;
  logic [7:0] trial, result;
  logic [3:0] ctrl;
  int n_mismatch = 0;
  int compares = 0;

  adc_conversion_control u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
    .converter_power_down_in(pd), .conversion_irq_enable_in(ie),
    .conversion_start_in(start), .cmp_high_in(cmp_high), .trial_code_out(trial),
    .analog_power_out(power), .busy_out(busy), .result_out(result),
    .converter_control_reg_out(ctrl), .eoc_out(eoc), .irq_out(irq));
  analog_front_model u_front (.trial_in(trial), .level_in(level), .cmp_high_out(cmp_high));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse_start();
    @(negedge clk_in);
    start = 1'b1;
    @(negedge clk_in);
    start = 1'b0;
  endtask

  task automatic wait_eoc(output int n);
    n = 0;
    while (eoc !== 1'b1 && n < CONV_CLK + 40) begin
      @(negedge clk_in);
      n++;
    end
  endtask

  task automatic convert(input logic signed [9:0] v, input logic ie_v);
    logic [7:0] exp;
    int n;
    exp = (v > 255) ? 8'hFF : (v < 0) ? 8'h00 : v[7:0];
    level = v;
    ie = ie_v;
    repeat (4) @(negedge clk_in);
    pulse_start();
    check8("busy", 8'h01, {7'h00, busy});
    check8("eoc_cleared", 8'h00, {7'h00, eoc});
    wait_eoc(n);
    check8("eoc_set", 8'h01, {7'h00, eoc});
    check8("conv_time", 8'h01, {7'h00, n >= CONV_CLK - 12 && n <= CONV_CLK + 14});
    check8("result", exp, result);
    check8("irq", {7'h00, ie_v}, {7'h00, irq});
    check8("start_reads_zero", 8'h00, {7'h00, ctrl[1]});
    check8("ctrl", {4'h0, 1'b0, ie_v, 1'b0, 1'b1}, {4'h0, ctrl});
  endtask

  task automatic test_reset();
    check8("reset_result", 8'h00, result);
    check8("reset_eoc", 8'h00, {7'h00, eoc});
    check8("power_off", 8'h00, {7'h00, power});
    pulse_start();
    repeat (3) @(negedge clk_in);
    check8("start_powered_down", 8'h00, {7'h00, busy});
  endtask

  task automatic test_power_up();
    pd = 1'b0;
    @(negedge clk_in);
    check8("analog_power", 8'h01, {7'h00, power});
    pulse_start();
    check8("start_settling", 8'h00, {7'h00, busy});
    repeat (adc_ctrl_pkg::SETTLE_TICKS * adc_ctrl_pkg::CLK_DIV + 24) @(negedge clk_in);
  endtask

  task automatic test_codes();
    int levels[8] = '{-5, 0, 1, 127, 128, 170, 255, 300};
    for (int i = 0; i < 8; i++) begin
      convert(levels[i][9:0], i[0]);
    end
  endtask

  task automatic test_restart();
    int n;
    convert(10'sd100, 1'b1);
    level = 10'sd200;
    repeat (4) @(negedge clk_in);
    pulse_start();
    check8("irq_cleared", 8'h00, {7'h00, irq});
    repeat (CONV_CLK / 2) @(negedge clk_in);
    pulse_start();
    wait_eoc(n);
    check8("restart_time", 8'h01, {7'h00, n >= CONV_CLK - 12});
    check8("restart_result", 8'hC8, result);
  endtask

  task automatic test_single_shot();
    repeat (3 * CONV_CLK) @(negedge clk_in);
    check8("no_repeat_busy", 8'h00, {7'h00, busy});
    check8("no_repeat_eoc", 8'h01, {7'h00, eoc});
    check8("no_repeat_result", 8'hC8, result);
    ie = 1'b0;
    repeat (2) @(negedge clk_in);
    check8("irq_masked", 8'h00, {7'h00, irq});
  endtask

  task automatic test_freeze();
    int n;
    level = 10'sd77;
    repeat (4) @(negedge clk_in);
    pulse_start();
    repeat (30) @(negedge clk_in);
    ce = 1'b0;
    repeat (50) @(negedge clk_in);
    check8("frozen_busy", 8'h01, {7'h00, busy});
    check8("frozen_eoc", 8'h00, {7'h00, eoc});
    ce = 1'b1;
    wait_eoc(n);
    check8("freeze_time", 8'h01, {7'h00, n >= CONV_CLK - 42 && n <= CONV_CLK - 16});
    check8("freeze_result", 8'h4D, result);
  endtask

  task automatic give_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    test_reset();
    test_power_up();
    test_codes();
    test_restart();
    test_single_shot();
    test_freeze();
    give_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk_in);
    n_mismatch++;
    $display("ERROR watchdog expected done seen timeout");
    give_verdict();
  end
endmodule
`default_nettype wire

// [hw/adc_conversion_control.sv]
// Conversion sequencer: power-up, start, completion flag, interrupt
// Assumes comparator input is asynchronous; no register bus, plain ports
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control #(
  parameter int SETTLE_TICKS = adc_ctrl_pkg::SETTLE_TICKS,
  parameter int CONV_TICKS = adc_ctrl_pkg::CONV_TICKS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic converter_power_down_in,
  input wire logic conversion_irq_enable_in,
  input wire logic conversion_start_in,
  input wire logic cmp_high_in,
  output logic [7:0] trial_code_out,
  output logic analog_power_out,
  output logic busy_out,
  output logic [7:0] result_out,
  output logic [3:0] converter_control_reg_out,
  output logic eoc_out,
  output logic irq_out
);
  localparam logic [7:0] SETTLE_N = 8'(SETTLE_TICKS);
  localparam logic [7:0] CONV_N = 8'(CONV_TICKS);
  localparam logic [7:0] SYNC_N = 8'h01;

  sar_if s();
  logic tick;
  logic cmp_s1_r, cmp_s2_r;
  adc_ctrl_pkg::conv_state_e state_r, state_nxt;
  logic [7:0] settle_r, settle_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] result_r, result_nxt;
  logic eoc_r, eoc_nxt;
  logic irq_r, irq_nxt;
  logic clear_c;

  tick_div #(.DIV(adc_ctrl_pkg::CLK_DIV)) u_div (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_out(tick)
  );

  sar_reg u_sar (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .s(s)
  );

  // Comparator from analog side, two stages
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else if (ce_in) begin
      cmp_s1_r <= cmp_high_in;
      cmp_s2_r <= cmp_s1_r;
    end
  end
  assign s.cmp_high = cmp_s2_r;
  assign s.tick = tick && (state_r == adc_ctrl_pkg::ST_CONV) && (cnt_r >= SYNC_N);
  assign s.clear = clear_c;

  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    cnt_nxt = cnt_r;
    result_nxt = result_r;
    eoc_nxt = eoc_r;
    irq_nxt = irq_r;
    clear_c = 1'b0;
    case (state_r)
      adc_ctrl_pkg::ST_OFF: begin
        if (!converter_power_down_in && tick) begin
          if (settle_r >= SETTLE_N - 8'h01) begin
            state_nxt = adc_ctrl_pkg::ST_IDLE;
          end else begin
            settle_nxt = 8'(settle_r + 8'h01);
          end
        end
      end
      adc_ctrl_pkg::ST_IDLE: begin
      end
      adc_ctrl_pkg::ST_CONV: begin
        if (tick) begin
          cnt_nxt = 8'(cnt_r + 8'h01);
        end
        if (tick && cnt_r == CONV_N - 8'h01) begin
          state_nxt = adc_ctrl_pkg::ST_DONE;
        end
      end
      adc_ctrl_pkg::ST_DONE: begin
        result_nxt = s.code;
        eoc_nxt = 1'b1;
        irq_nxt = conversion_irq_enable_in;
        state_nxt = adc_ctrl_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = adc_ctrl_pkg::ST_OFF;
      end
    endcase
    if (conversion_start_in && state_r != adc_ctrl_pkg::ST_OFF
        && !converter_power_down_in) begin
      state_nxt = adc_ctrl_pkg::ST_CONV;
      cnt_nxt = 8'h00;
      clear_c = 1'b1;
      eoc_nxt = 1'b0;
      irq_nxt = 1'b0;
    end
    if (!conversion_irq_enable_in) begin
      irq_nxt = 1'b0;
    end
    if (converter_power_down_in) begin
      state_nxt = adc_ctrl_pkg::ST_OFF;
      settle_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= adc_ctrl_pkg::ST_OFF;
      settle_r <= 8'h00;
      cnt_r <= 8'h00;
      result_r <= adc_ctrl_pkg::RESULT_RST;
      eoc_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      cnt_r <= cnt_nxt;
      result_r <= result_nxt;
      eoc_r <= eoc_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign trial_code_out = s.trial;
  assign analog_power_out = !converter_power_down_in;
  assign busy_out = (state_r == adc_ctrl_pkg::ST_CONV);
  assign result_out = result_r;
  assign eoc_out = eoc_r;
  assign irq_out = irq_r;
  assign converter_control_reg_out = {converter_power_down_in, conversion_irq_enable_in,
    1'b0, eoc_r};

  AST_START_CLEARS_EOC: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && conversion_start_in && state_r != adc_ctrl_pkg::ST_OFF
    && !converter_power_down_in |=> !eoc_r && !irq_r) else $error("start kept flag");
  AST_DONE_SETS_EOC: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && state_r == adc_ctrl_pkg::ST_DONE && !conversion_start_in
    && !converter_power_down_in |=> eoc_r) else $error("eoc not set");
  AST_RESULT_STORED: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && state_r == adc_ctrl_pkg::ST_DONE |=> result_r == $past(s.code))
    else $error("result not stored");
  AST_IRQ_NEEDS_EN: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(irq_r) |-> $past(conversion_irq_enable_in)) else $error("irq without enable");
  AST_IRQ_HAS_EOC: assert property (@(posedge clk_in) disable iff (rst_in)
    irq_r |-> eoc_r) else $error("irq without eoc");
  AST_ONE_CONV: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == adc_ctrl_pkg::ST_DONE |=> state_r != adc_ctrl_pkg::ST_CONV
    || $past(conversion_start_in)) else $error("auto restart");
  AST_START_READ_ZERO: assert property (@(posedge clk_in) disable iff (rst_in)
    converter_control_reg_out[adc_ctrl_pkg::CTRL_ST_BIT] == 1'b0)
    else $error("start bit read one");
  AST_PD_STOPS: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && converter_power_down_in |=> state_r == adc_ctrl_pkg::ST_OFF)
    else $error("powered down but active");
  AST_RESTART: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && busy_out && conversion_start_in && !converter_power_down_in
    |=> busy_out && cnt_r == 8'h00) else $error("no restart");

  logic [7:0] seen_r, seen_nxt;
  always_comb begin
    seen_nxt = seen_r;
    if (clear_c) begin
      seen_nxt = 8'h00;
    end else if (tick && busy_out) begin
      seen_nxt = 8'(seen_r + 8'h01);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seen_r <= 8'h00;
    end else if (ce_in) begin
      seen_r <= seen_nxt;
    end
  end

  AST_CONV_LENGTH: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(eoc_r) |-> seen_r == CONV_N) else $error("conversion length wrong");
  AST_CNT_BOUND: assert property (@(posedge clk_in) disable iff (rst_in)
    busy_out |-> cnt_r < CONV_N) else $error("conversion count overrun");
  AST_SAR_DONE_IN_CONV: assert property (@(posedge clk_in) disable iff (rst_in)
    s.done |-> busy_out || $past(converter_power_down_in))
    else $error("sar finished outside conversion");
  AST_CE_FREEZE: assert property (@(posedge clk_in) disable iff (rst_in)
    !ce_in |=> $stable(state_r) && $stable(result_r) && $stable(eoc_r) && $stable(irq_r))
    else $error("state moved while frozen");
  AST_START_REFUSED_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && state_r == adc_ctrl_pkg::ST_OFF |=> !busy_out)
    else $error("start taken while off");
  AST_SETTLE_BOUND: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == adc_ctrl_pkg::ST_OFF |-> settle_r < SETTLE_N)
    else $error("settle count overrun");
  AST_IRQ_DROPS_NO_EN: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !conversion_irq_enable_in |=> !irq_r) else $error("irq kept without enable");
  AST_EOC_ONLY_DONE: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(eoc_r) |-> $past(state_r) == adc_ctrl_pkg::ST_DONE)
    else $error("eoc set outside completion");
  AST_RESULT_ONLY_DONE: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(result_r) |-> $past(state_r) == adc_ctrl_pkg::ST_DONE)
    else $error("result changed outside completion");
  AST_START_IN_DONE: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && state_r == adc_ctrl_pkg::ST_DONE && conversion_start_in
    && !converter_power_down_in |=> busy_out) else $error("start lost at completion");
endmodule
`default_nettype wire

// [hw/adc_ctrl_pkg.sv]
// Constants and types for the converter control block
// Assumes a single 100 MHz clock domain and synchronous reset
package adc_ctrl_pkg;
  localparam int DATA_W = 8;
  localparam int CLK_DIV = 12;
  localparam int SETTLE_TICKS = 2;
  localparam int CONV_TICKS = 10;
  localparam logic [7:0] CODE_FULL = 8'hFF;
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] MSB_BIT = 8'h80;
  localparam int CTRL_W = 4;
  localparam int CTRL_PD_BIT = 3;
  localparam int CTRL_IE_BIT = 2;
  localparam int CTRL_ST_BIT = 1;
  localparam int CTRL_EOC_BIT = 0;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_IDLE = 4'h2,
    ST_CONV = 4'h4,
    ST_DONE = 4'h8
  } conv_state_e;
endpackage

// [hw/sar_if.sv]
// Handshake between sequencer and successive approximation register
// Assumes both ends run on clk_in
`timescale 1ns/1ps
`default_nettype none
interface sar_if;
  logic tick;
  logic clear;
  logic cmp_high;
  logic [7:0] trial;
  logic [7:0] code;
  logic done;
  modport seq (output tick, output clear, input trial, input code, input done);
  modport sar (input tick, input clear, input cmp_high, output trial, output code,
    output done);
endinterface
`default_nettype wire

// [hw/sar_reg.sv]
// Successive approximation register, one bit per converter tick
// Assumes cmp_high reflects comparator for the current trial code
`timescale 1ns/1ps
`default_nettype none
module sar_reg (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  sar_if.sar s
);
  logic [7:0] code_r, code_nxt;
  logic [7:0] bit_r, bit_nxt;
  logic done_r, done_nxt;

  always_comb begin
    code_nxt = code_r;
    bit_nxt = bit_r;
    done_nxt = 1'b0;
    if (s.clear) begin
      code_nxt = adc_ctrl_pkg::CODE_ZERO;
      bit_nxt = adc_ctrl_pkg::MSB_BIT;
    end else if (s.tick && bit_r != 8'h00) begin
      if (s.cmp_high) begin
        code_nxt = code_r | bit_r;
      end
      bit_nxt = bit_r >> 1;
      done_nxt = (bit_r == 8'h01);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      code_r <= adc_ctrl_pkg::CODE_ZERO;
      bit_r <= 8'h00;
      done_r <= 1'b0;
    end else if (ce_in) begin
      code_r <= code_nxt;
      bit_r <= bit_nxt;
      done_r <= done_nxt;
    end
  end

  assign s.trial = code_r | bit_r;
  assign s.code = code_r;
  assign s.done = done_r;
endmodule
`default_nettype wire

// [hw/tick_div.sv]
// Divide-by-twelve converter clock enable
// Assumes clk_in is the internal clock
`timescale 1ns/1ps
`default_nettype none
module tick_div #(
  parameter int DIV = adc_ctrl_pkg::CLK_DIV
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  output logic tick_out
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (ce_in) begin
      cnt_nxt = (cnt_r == 8'(DIV - 1)) ? 8'h00 : 8'(cnt_r + 8'h01);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick_out = ce_in && (cnt_r == 8'(DIV - 1));

  AST_TICK_SPACING: assert property (@(posedge clk_in) disable iff (rst_in)
    tick_out |=> !tick_out) else $error("tick repeated");
endmodule
`default_nettype wire
